// ===== hdl/pmt_target.sv
// Target end of the management bus: transactions, status and alert.
// Assumes the bus clock and data arrive from another domain and that a
// host keeps the clock low no shorter than a few system clock cycles.
module pmt_target (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // Bus pins
    pmt_if.target                  bus,
    // Configuration
    input  wire logic [6:0]        dev_addr,
    input  wire logic              smbus_mode,
    // Rail telemetry and fault events
    input  wire logic [1:0][15:0]  vout_meas,
    input  wire logic [1:0][7:0]   fault_set,
    // Commands towards the rail logic
    output logic                   wr_stb,
    output logic [7:0]             wr_cmd,
    output logic [15:0]            wr_data,
    output logic                   rail_sel,
    output logic                   clr_faults,
    output logic                   pec_err
);
    // ==========================================================
    // Command lengths
    function automatic logic [2:0] wlen(input logic [7:0] c);
        if (c == pmt_pkg::CMD_CLEAR) begin
            return 3'd0;
        end
        if (c == pmt_pkg::CMD_PAGE) begin
            return 3'd1;
        end
        return 3'd2;
    endfunction : wlen

    typedef enum logic [2:0] {
        T_IDLE, T_RX, T_RACK, T_TX, T_TACK
    } pmt_tst_t;

    // ==========================================================
    // Pin synchronisers and bus events
    logic        scl_m;
    logic        scl_s;
    logic        scl_d;
    logic        sda_m;
    logic        sda_s;
    logic        sda_d;

    always_ff @(posedge mclk) begin
        if (rst) begin
            {scl_m, scl_s, scl_d} <= 3'b111;
            {sda_m, sda_s, sda_d} <= 3'b111;
        end else begin
            {scl_m, scl_s, scl_d} <= {bus.scl, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {bus.sda, sda_m, sda_s};
        end
    end

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

    // ==========================================================
    // State
    pmt_tst_t         st;
    logic [7:0]       sh;
    logic [3:0]       bitc;
    logic             is_addr;
    logic             rd_mode;
    logic             ara_sel;
    logic             wr_seg;
    logic             host_ack;
    logic [1:0]       idx;
    logic [2:0]       nb;
    logic [7:0]       cmd;
    logic [7:0]       d0;
    logic [7:0]       d1;
    logic [7:0]       crc;
    logic             sda_oe;
    logic             page;
    logic             alert_pend;
    logic [1:0][7:0]  status;

    // ==========================================================
    // Decoding
    wire [6:0] rx_addr = sh[7:1];
    wire       m_dev   = rx_addr == dev_addr;
    wire       m_ara   = smbus_mode & sh[0] & alert_pend
                         & (rx_addr == pmt_pkg::ARA_ADDR);
    wire       take    = m_dev | m_ara;

    wire [2:0] ndata    = nb - 3'd1;
    wire [2:0] want     = wlen(cmd);
    wire       len_ok   = (nb != 3'd0) & (ndata == want);
    wire       len_pec  = (nb != 3'd0) & (ndata == want + 3'd1);
    wire       crc_zero = crc == 8'h00;
    // A trailing error byte folds the running code to zero when intact.
    wire       do_exec  = stop_c & wr_seg
                          & (len_ok | (len_pec & crc_zero));
    wire       do_clear = do_exec & (cmd == pmt_pkg::CMD_CLEAR);
    wire       bad_pec  = stop_c & wr_seg & len_pec & ~crc_zero;

    wire [15:0] rword = ara_sel ? {8'h00, dev_addr, 1'b0}
        : (cmd == pmt_pkg::CMD_VOUT) ? vout_meas[page]
        : (cmd == pmt_pkg::CMD_STATUS) ? {8'h00, status[page]}
        : (cmd == pmt_pkg::CMD_PAGE) ? {15'h0000, page}
        : 16'hFFFF;
    wire        short_rd = ara_sel | (cmd == pmt_pkg::CMD_STATUS)
                           | (cmd == pmt_pkg::CMD_PAGE);
    wire [1:0]  rlen     = short_rd ? 2'd1 : 2'd2;
    // Bytes past the data carry the error code, then idle ones.
    wire [7:0]  tx_byte  = (idx < rlen) ? ((idx == 2'd0) ? rword[7:0]
                                                      : rword[15:8])
                         : (idx == rlen) ? crc : pmt_pkg::IDLE_BYTE;
    wire        ara_rel  = (st == T_RACK) & scl_fall & rd_mode
                           & ara_sel;

    // ==========================================================
    // Byte engine
    always_ff @(posedge mclk) begin
        if (rst) begin
            st       <= T_IDLE;
            sh       <= 8'h00;
            bitc     <= 4'h0;
            is_addr  <= 1'b0;
            rd_mode  <= 1'b0;
            ara_sel  <= 1'b0;
            wr_seg   <= 1'b0;
            host_ack <= 1'b0;
            idx      <= 2'd0;
            nb       <= 3'd0;
            cmd      <= 8'h00;
            d0       <= 8'h00;
            d1       <= 8'h00;
            crc      <= pmt_pkg::CRC_INIT;
            sda_oe   <= 1'b0;
        end else if (start_c) begin
            // A repeated start keeps a pending write for group commands.
            st      <= T_RX;
            is_addr <= 1'b1;
            bitc    <= 4'h0;
            idx     <= 2'd0;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            st     <= T_IDLE;
            wr_seg <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            unique case (st)
                T_IDLE: begin
                end
                T_RX: begin
                    if (scl_rise) begin
                        sh   <= {sh[6:0], sda_s};
                        bitc <= bitc + 4'h1;
                    end else if (scl_fall && bitc == 4'h8) begin
                        if (!is_addr) begin
                            sda_oe <= 1'b1;
                            st     <= T_RACK;
                            crc    <= pmt_pkg::crc8(crc, sh);
                            if (nb == 3'd0) begin
                                cmd <= sh;
                            end else if (nb == 3'd1) begin
                                d0 <= sh;
                            end else if (nb == 3'd2) begin
                                d1 <= sh;
                            end
                            if (nb != 3'd7) begin
                                nb <= nb + 3'd1;
                            end
                        end else if (take) begin
                            sda_oe  <= 1'b1;
                            st      <= T_RACK;
                            rd_mode <= sh[0];
                            ara_sel <= m_ara;
                            if (m_ara || !sh[0]) begin
                                crc <= pmt_pkg::crc8(pmt_pkg::CRC_INIT, sh);
                            end else begin
                                // Read keeps the code begun by the write.
                                crc <= pmt_pkg::crc8(crc, sh);
                            end
                            if (m_dev && !sh[0]) begin
                                wr_seg <= 1'b1;
                                nb     <= 3'd0;
                            end else if (m_dev) begin
                                wr_seg <= 1'b0;
                            end
                        end else begin
                            st <= T_IDLE;
                        end
                    end
                end
                T_RACK: begin
                    if (scl_fall) begin
                        is_addr <= 1'b0;
                        bitc    <= 4'h0;
                        if (rd_mode) begin
                            sh     <= tx_byte;
                            crc    <= pmt_pkg::crc8(crc, tx_byte);
                            idx    <= idx + 2'd1;
                            sda_oe <= ~tx_byte[7];
                            bitc   <= 4'h1;
                            st     <= T_TX;
                        end else begin
                            sda_oe <= 1'b0;
                            st     <= T_RX;
                        end
                    end
                end
                T_TX: begin
                    if (scl_fall && bitc == 4'h8) begin
                        sda_oe <= 1'b0;
                        st     <= T_TACK;
                    end else if (scl_fall) begin
                        sda_oe <= ~sh[6];
                        sh     <= {sh[6:0], 1'b0};
                        bitc   <= bitc + 4'h1;
                    end
                end
                T_TACK: begin
                    if (scl_rise) begin
                        host_ack <= ~sda_s;
                    end else if (scl_fall && host_ack) begin
                        sh     <= tx_byte;
                        crc    <= pmt_pkg::crc8(crc, tx_byte);
                        idx    <= idx + 2'd1;
                        sda_oe <= ~tx_byte[7];
                        bitc   <= 4'h1;
                        st     <= T_TX;
                    end else if (scl_fall) begin
                        st <= T_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Status, alert and command outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            status     <= '0;
            alert_pend <= 1'b0;
            page       <= pmt_pkg::PAGE_RST;
            wr_stb     <= 1'b0;
            wr_cmd     <= 8'h00;
            wr_data    <= 16'h0000;
            clr_faults <= 1'b0;
            pec_err    <= 1'b0;
        end else begin
            // New faults win over a clear in the same cycle.
            for (int r = 0; r < 2; r++) begin
                if (do_clear && page == r[0]) begin
                    status[r] <= fault_set[r];
                end else begin
                    status[r] <= status[r] | fault_set[r];
                end
            end
            alert_pend <= (|fault_set)
                          | (alert_pend & ~do_clear & ~ara_rel);
            if (do_exec && cmd == pmt_pkg::CMD_PAGE) begin
                page <= d0[0];
            end
            wr_stb     <= do_exec;
            clr_faults <= do_clear;
            pec_err    <= bad_pec;
            if (do_exec) begin
                wr_cmd  <= cmd;
                wr_data <= {d1, d0};
            end
        end
    end

    assign rail_sel       = page;
    assign bus.sda_o_t    = 1'b0;
    assign bus.sda_oe_t   = sda_oe;
    assign bus.alert_o_t  = 1'b0;
    assign bus.alert_oe_t = alert_pend;
endmodule : pmt_target

// ===== hdl/pmt_pkg.sv
// Shared constants, types and the packet error code for both bus ends.
// Assumes one 200 MHz clock on each end and an open-drain two-wire bus.
package pmt_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ  = 200_000_000;
    localparam int unsigned SCL_HZ  = 1_000_000;
    localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);

    // ==========================================================
    // Addresses and command codes
    localparam logic [6:0] ARA_ADDR   = 7'h0C;
    localparam logic [7:0] CMD_PAGE   = 8'h00;
    localparam logic [7:0] CMD_CLEAR  = 8'h03;
    localparam logic [7:0] CMD_STATUS = 8'h78;
    localparam logic [7:0] CMD_VOUT   = 8'h8B;
    localparam logic [7:0] IDLE_BYTE  = 8'hFF;
    localparam logic [7:0] CRC_POLY   = 8'h07;
    localparam logic [7:0] CRC_INIT   = 8'h00;
    localparam logic       PAGE_RST   = 1'b0;

    // ==========================================================
    // Host operations
    typedef enum logic [2:0] {
        OP_SEND, OP_WBYTE, OP_WWORD, OP_RBYTE, OP_RWORD, OP_ARA
    } pmt_op_t;

    // ==========================================================
    // Packet error code, one byte folded into a running value.
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc8
endpackage : pmt_pkg

// ===== hdl/pmt_if.sv
// Two-wire management bus between the host end and the target end.
// Assumes pull-ups: a wire is low whenever any enabled driver drives low.
interface pmt_if;
    logic scl_o_h;
    logic scl_oe_h;
    logic sda_o_h;
    logic sda_oe_h;
    logic sda_o_t;
    logic sda_oe_t;
    logic alert_o_t;
    logic alert_oe_t;
    logic scl;
    logic sda;
    logic bus_alert_out_n;

    assign scl = ~(scl_oe_h & ~scl_o_h);
    assign sda = ~((sda_oe_h & ~sda_o_h) | (sda_oe_t & ~sda_o_t));
    assign bus_alert_out_n = ~(alert_oe_t & ~alert_o_t);

    modport target (input scl, input sda, output sda_o_t,
                    output sda_oe_t, output alert_o_t, output alert_oe_t);
    modport host (output scl_o_h, output scl_oe_h, output sda_o_h,
                  output sda_oe_h, input sda, input bus_alert_out_n);
endinterface : pmt_if

// ===== hdl/pmt_host.sv
// Host end of the management bus: issues one transaction per command, or one per group of commands joined by write commands with cmd_chain set.
// Assumes the target never stretches the clock; alert and data pins
// come from another domain and are synchronised here.
module pmt_host (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Bus pins
    pmt_if.host                   bus,
    // Command request
    input  wire logic             cmd_valid,
    input  wire pmt_pkg::pmt_op_t cmd_op,
    input  wire logic [6:0]       cmd_addr,
    input  wire logic [7:0]       cmd_code,
    input  wire logic [15:0]      cmd_data,
    input  wire logic             cmd_pec,
    input  wire logic             cmd_chain,
    // Command answer
    output logic                  cmd_ready,
    output logic                  done,
    output logic                  nack_err,
    output logic                  pec_err,
    output logic [15:0]           rdata,
    output logic                  alert_seen
);
    typedef enum logic [2:0] {
        H_IDLE, H_START, H_WBYTE, H_RBYTE, H_STOP, H_HOLD
    } pmt_hst_t;

    pmt_hst_t          st;
    pmt_pkg::pmt_op_t  op;
    logic [6:0]        addr;
    logic [7:0]        code;
    logic [15:0]       data;
    logic              pec;
    logic              chain;
    logic [1:0]        q;
    logic [7:0]        qcnt;
    logic [3:0]        bitn;
    logic [7:0]        sh;
    logic [2:0]        widx;
    logic [1:0]        ridx;
    logic              rd_phase;
    logic              ack_ok;
    logic [7:0]        crc;
    logic              scl_oe;
    logic              sda_oe;
    logic [1:0]        sda_m;
    logic [1:0]        alr_m;

    // ==========================================================
    // Decoding
    wire       tick    = qcnt == 8'(pmt_pkg::QTR_CYC - 1);
    wire       is_read = (op == pmt_pkg::OP_RBYTE)
                         | (op == pmt_pkg::OP_RWORD)
                         | (op == pmt_pkg::OP_ARA);
    wire [2:0] ndata   = (op == pmt_pkg::OP_WBYTE) ? 3'd1
                       : (op == pmt_pkg::OP_WWORD) ? 3'd2 : 3'd0;
    wire [2:0] nw      = 3'd2 + ndata + {2'b00, pec & ~is_read};
    wire [1:0] nr      = ((op == pmt_pkg::OP_RWORD) ? 2'd2 : 2'd1)
                         + {1'b0, pec};
    wire       last_rd = ridx == nr - 2'd1;
    wire [6:0] rd_addr = (op == pmt_pkg::OP_ARA) ? pmt_pkg::ARA_ADDR
                                                : addr;
    wire [7:0] cur_w   = rd_phase ? {rd_addr, 1'b1}
        : (pec && !is_read && widx == nw - 3'd1) ? crc
        : (widx == 3'd0) ? {addr, 1'b0}
        : (widx == 3'd1) ? code
        : (widx == 3'd2) ? data[7:0] : data[15:8];
    wire       byte_st = (st == H_WBYTE) | (st == H_RBYTE);
    wire       low_q   = (q == 2'd0) | (q == 2'd3);
    wire       next_scl_oe = ((st == H_START | byte_st) & low_q)
                             | (st == H_STOP & q == 2'd0)
                             | (st == H_HOLD);
    wire       next_sda_oe = (st == H_START & q[1])
                             | (st == H_STOP & ~q[1])
                             | (st == H_WBYTE & ~bitn[3]
                                & ~cur_w[3'd7 - bitn[2:0]])
                             | (st == H_RBYTE & bitn[3] & ~last_rd);
    wire       accept  = cmd_valid & cmd_ready;
    wire [7:0] crc_rd  = pmt_pkg::crc8(crc, sh);

    // ==========================================================
    // Sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            st        <= H_IDLE;
            op        <= pmt_pkg::OP_SEND;
            {addr, code, data, pec, chain} <= '0;
            {q, qcnt, bitn, sh, widx, ridx} <= '0;
            {rd_phase, ack_ok} <= 2'b00;
            crc       <= pmt_pkg::CRC_INIT;
            cmd_ready <= 1'b0;
            done      <= 1'b0;
            nack_err  <= 1'b0;
            pec_err   <= 1'b0;
            rdata     <= 16'h0000;
            {scl_oe, sda_oe} <= 2'b00;
        end else begin
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            done   <= 1'b0;
            qcnt   <= (tick || st == H_IDLE || st == H_HOLD) ? 8'h00
                                                            : qcnt + 8'h01;
            if (st == H_IDLE || st == H_HOLD) begin
                cmd_ready <= ~accept;
            end
            if (tick) begin
                q <= q + 2'd1;
            end
            if (accept) begin
                op                 <= cmd_op;
                {addr, code, data} <= {cmd_addr, cmd_code, cmd_data};
                {pec, chain} <= {cmd_pec, cmd_chain};
                {q, widx, ridx} <= '0;
                rd_phase <= cmd_op == pmt_pkg::OP_ARA;
                crc      <= pmt_pkg::CRC_INIT;
                nack_err <= 1'b0;
                pec_err  <= 1'b0;
                st       <= H_START;
            end else if (tick && q == 2'd2 && byte_st) begin
                if (st == H_WBYTE) begin
                    ack_ok <= ~sda_m[1];
                end else if (!bitn[3]) begin
                    sh <= {sh[6:0], sda_m[1]};
                end
            end else if (tick && q == 2'd3) begin
                unique case (st)
                    H_IDLE, H_HOLD: begin
                    end
                    H_START: begin
                        st   <= H_WBYTE;
                        bitn <= 4'h0;
                    end
                    H_WBYTE: begin
                        bitn <= bitn + 4'h1;
                        if (bitn[3]) begin
                            crc  <= pmt_pkg::crc8(crc, cur_w);
                            bitn <= 4'h0;
                            widx <= widx + 3'd1;
                            if (!ack_ok) begin
                                nack_err <= 1'b1;
                                st       <= H_STOP;
                            end else if (rd_phase) begin
                                st <= H_RBYTE;
                            end else if (widx + 3'd1 != nw) begin
                                st <= H_WBYTE;
                            end else if (is_read) begin
                                rd_phase <= 1'b1;
                                st       <= H_START;
                            end else begin
                                st <= chain ? H_HOLD : H_STOP;
                            end
                        end
                        if (bitn[3] && ack_ok && !rd_phase
                            && widx + 3'd1 == nw && !is_read && chain) begin
                            done      <= 1'b1;
                            cmd_ready <= 1'b1;
                        end
                    end
                    H_RBYTE: begin
                        bitn <= bitn + 4'h1;
                        if (bitn[3]) begin
                            crc  <= crc_rd;
                            bitn <= 4'h0;
                            ridx <= ridx + 2'd1;
                            if (ridx == 2'd0) begin
                                rdata[7:0] <= sh;
                            end else if (op == pmt_pkg::OP_RWORD
                                         && ridx == 2'd1) begin
                                rdata[15:8] <= sh;
                            end
                            if (last_rd) begin
                                pec_err <= pec & (crc_rd != 8'h00);
                                st      <= H_STOP;
                            end
                        end
                    end
                    H_STOP: begin
                        st        <= H_IDLE;
                        done      <= 1'b1;
                        cmd_ready <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Input synchronisers
    always_ff @(posedge mclk) begin
        if (rst) begin
            sda_m      <= 2'b11;
            alr_m      <= 2'b11;
            alert_seen <= 1'b0;
        end else begin
            sda_m      <= {sda_m[0], bus.sda};
            alr_m      <= {alr_m[0], bus.bus_alert_out_n};
            alert_seen <= ~alr_m[1];
        end
    end

    assign bus.scl_o_h  = 1'b0;
    assign bus.scl_oe_h = scl_oe;
    assign bus.sda_o_h  = 1'b0;
    assign bus.sda_oe_h = sda_oe;
endmodule : pmt_host

// ===== tb/pmt_monitor.sv
// Checker of the wires and drives between the host and target ends.
// Assumes it is fed the plain signals of the joining interface.
module pmt_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Drives and wires
    input wire logic sda_oe_h,
    input wire logic sda_o_t,
    input wire logic sda_oe_t,
    input wire logic alert_o_t,
    input wire logic alert_oe_t,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence start_s; scl && $fell(sda); endsequence
    sequence stop_s; scl && $rose(sda); endsequence
    tgt_low_a: assert property (sda_oe_t |-> !sda_o_t)
        else $error("target drives data high");
    no_fight_a: assert property (sda_oe_t && sda_oe_h |-> !scl)
        else $error("both ends drive data while clock high");
    tgt_hold_a: assert property (scl && $past(scl) |-> $stable(sda_oe_t))
        else $error("target data moved while clock high");
    scl_high_a: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high too short");
    scl_low_a: assert property ($fell(scl) |-> (!scl)[*8])
        else $error("clock low too short");
    start_end_a: assert property (start_s |-> ##[1:60] !scl)
        else $error("start not followed by clock low");
    stop_idle_a: assert property (stop_s |=> (scl && sda)[*8])
        else $error("bus not idle after stop");
    alert_low_a: assert property (alert_oe_t |-> !alert_o_t)
        else $error("alert driven high");
endmodule : pmt_monitor

// ===== tb/test_pmbus_target_transactions.sv
// Bench: the host end talks to the target end through the bus interface.
// Assumes one bus bit takes 200 system clocks; whole run near 65k cycles.
module test_pmbus_target_transactions;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ADDR = 7'h2A;
    logic mclk = 0, rst = 1, cmd_valid = 0, cmd_pec = 0, smbus_mode = 0;
    logic [1:0][15:0] vout_meas = {16'h0BEA, 16'h0384};
    logic [1:0][7:0] fault_set = '0;
    pmt_pkg::pmt_op_t cmd_op = pmt_pkg::OP_SEND;
    logic [6:0] cmd_addr = ADDR;
    logic [7:0] cmd_code = 8'h00, wr_cmd;
    logic [15:0] cmd_data = 16'h0000, rdata, wr_data;
    logic cmd_ready, done, nack_err, h_pec, alert_seen, cmd_chain = 0;
    logic wr_stb, rail_sel, clr_faults, pec_err;
    int error_cnt = 0, samples_checked = 0, cyc = 0, clr_cnt = 0, pe_cnt = 0;
    pmt_if bus ();
    pmt_host i_pmt_host (.mclk(mclk), .rst(rst), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_pec(cmd_pec),
        .cmd_chain(cmd_chain), .cmd_ready(cmd_ready), .done(done),
        .nack_err(nack_err), .pec_err(h_pec), .rdata(rdata),
        .alert_seen(alert_seen));
    pmt_target i_pmt_target (.mclk(mclk), .rst(rst), .bus(bus),
        .dev_addr(ADDR), .smbus_mode(smbus_mode), .vout_meas(vout_meas),
        .fault_set(fault_set), .wr_stb(wr_stb), .wr_cmd(wr_cmd),
        .wr_data(wr_data), .rail_sel(rail_sel), .clr_faults(clr_faults),
        .pec_err(pec_err));
    pmt_monitor i_pmt_monitor (.mclk(mclk), .rst(rst),
        .sda_oe_h(bus.sda_oe_h), .sda_o_t(bus.sda_o_t),
        .sda_oe_t(bus.sda_oe_t), .alert_o_t(bus.alert_o_t),
        .alert_oe_t(bus.alert_oe_t), .scl(bus.scl), .sda(bus.sda));
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        clr_cnt += (clr_faults === 1'b1);
        pe_cnt += (pec_err === 1'b1);
        if (cyc == 90000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input pmt_pkg::pmt_op_t op, input logic [7:0] c,
                        input logic [15:0] d, input logic [6:0] a = ADDR);
        while (cmd_ready !== 1'b1) @(negedge mclk);
        cmd_op = op;
        cmd_addr = a;
        cmd_code = c;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (done !== 1'b1) @(negedge mclk);
    endtask : xfer
    task automatic raise();
        fault_set[0] = 8'h10;
        @(negedge mclk);
        fault_set[0] = 8'h00;
        repeat (6) @(negedge mclk);
    endtask : raise
    task automatic t_write();
        cmd_pec = 1'b1;
        xfer(pmt_pkg::OP_WWORD, 8'h21, 16'h1234);
        cmd_pec = 1'b0;
        chk({8'h00, wr_cmd}, 16'h0021);
        chk(wr_data, 16'h1234);
        chk({nack_err, h_pec, 6'h00, pe_cnt[7:0]}, 16'h0000);
        $display("test write done");
    endtask : t_write
    task automatic t_alert();
        raise();
        chk({14'h0000, bus.bus_alert_out_n, alert_seen}, 16'h0001);
        xfer(pmt_pkg::OP_ARA, 8'h00, 16'h0000);
        chk({15'h0000, nack_err}, 16'h0001);
        smbus_mode = 1'b1;
        xfer(pmt_pkg::OP_ARA, 8'h00, 16'h0000);
        chk({9'h000, rdata[7:1]}, {9'h000, ADDR});
        chk({14'h0000, bus.bus_alert_out_n, alert_seen}, 16'h0002);
        $display("test alert done");
    endtask : t_alert
    task automatic t_clear();
        raise();
        xfer(pmt_pkg::OP_SEND, pmt_pkg::CMD_CLEAR, 16'h0000);
        chk({bus.bus_alert_out_n, clr_cnt[14:0]}, 16'h8001);
        xfer(pmt_pkg::OP_RBYTE, pmt_pkg::CMD_STATUS, 16'h0000);
        chk({8'h00, rdata[7:0]}, 16'h0000);
        $display("test clear done");
    endtask : t_clear
    task automatic t_read();
        cmd_pec = 1'b1;
        xfer(pmt_pkg::OP_RWORD, pmt_pkg::CMD_VOUT, 16'h0000);
        cmd_pec = 1'b0;
        chk(rdata, 16'h0384);
        chk({15'h0000, h_pec}, 16'h0000);
        xfer(pmt_pkg::OP_WBYTE, pmt_pkg::CMD_PAGE, 16'h0001);
        chk({15'h0000, rail_sel}, 16'h0001);
        xfer(pmt_pkg::OP_RWORD, pmt_pkg::CMD_VOUT, 16'h0000);
        chk(rdata, 16'h0BEA);
        xfer(pmt_pkg::OP_SEND, pmt_pkg::CMD_CLEAR, 16'h0000, 7'h2B);
        chk({15'h0000, nack_err}, 16'h0001);
        $display("test read done");
    endtask : t_read
    task automatic t_group();
        cmd_chain = 1'b1;
        xfer(pmt_pkg::OP_WWORD, 8'h22, 16'h5678);
        cmd_chain = 1'b0;
        chk({8'h00, wr_cmd}, 16'h0000);
        xfer(pmt_pkg::OP_SEND, pmt_pkg::CMD_CLEAR, 16'h0000, 7'h2B);
        chk({8'h00, wr_cmd}, 16'h0022);
        chk(wr_data, 16'h5678);
        $display("test group done");
    endtask : t_group
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (8) @(negedge mclk);
        t_write();
        t_alert();
        t_clear();
        t_read();
        t_group();
        conclude();
    end
endmodule : test_pmbus_target_transactions
